// File: core/spt_pkg.sv
// constants, register map and types for the panel timing generator
package spt_pkg;

	localparam int CW  = 12;
	localparam int CFW = 8;
	localparam int AW  = 8;
	localparam int DW  = 32;
	localparam int PDW = 18;

	typedef logic [CW-1:0]  spt_cnt_t;
	typedef logic [CFW-1:0] spt_cfg_t;

	// register byte offsets
	localparam logic [AW-1:0] SPT_CTRL_OFS = 8'h00;
	localparam logic [AW-1:0] SPT_CLK_OFS  = 8'h04;
	localparam logic [AW-1:0] SPT_HTOT_OFS = 8'h08;
	localparam logic [AW-1:0] SPT_HSYN_OFS = 8'h0c;
	localparam logic [AW-1:0] SPT_HSTA_OFS = 8'h10;
	localparam logic [AW-1:0] SPT_VTOT_OFS = 8'h14;
	localparam logic [AW-1:0] SPT_VSYN_OFS = 8'h18;
	localparam logic [AW-1:0] SPT_PNLA_OFS = 8'h1c;
	localparam logic [AW-1:0] SPT_PNLB_OFS = 8'h20;
	localparam logic [AW-1:0] SPT_PNLC_OFS = 8'h24;
	localparam logic [AW-1:0] SPT_STAT_OFS = 8'h28;

	// control bits
	localparam int SPT_EN_BIT     = 0;
	localparam int SPT_PCTL_BIT   = 1;
	localparam int SPT_TV_BIT     = 2;
	localparam int SPT_VSLINE_BIT = 3;
	localparam int SPT_CLKINV_BIT = 4;
	localparam int SPT_HSHI_BIT   = 5;
	localparam int SPT_VSHI_BIT   = 6;
	localparam int SPT_DVHI_BIT   = 7;

	// field positions
	localparam int SPT_LO_LSB   = 0;
	localparam int SPT_HI_LSB   = 16;
	localparam int SPT_PER_LSB  = 0;
	localparam int SPT_FALL_LSB = 8;
	localparam int SPT_RISE_LSB = 16;
	localparam int SPT_DIV_LSB  = 24;
	localparam int SPT_RUN_BIT  = 28;
	localparam int SPT_FLD_BIT  = 29;
	localparam int SPT_TV_LSB   = 10;
	localparam int SPT_TV_W     = 8;

	// write masks and reset values
	localparam logic [DW-1:0] SPT_CTRL_MASK = 32'h0000_00ff;
	localparam logic [DW-1:0] SPT_PAIR_MASK = 32'h0fff_0fff;
	localparam logic [DW-1:0] SPT_LO_MASK   = 32'h0000_0fff;
	localparam logic [DW-1:0] SPT_CTRL_RST  = 32'h0000_0000;
	localparam logic [DW-1:0] SPT_CLK_RST   = 32'h0004_0804;
	localparam logic [DW-1:0] SPT_TIME_RST  = 32'h0000_0000;

	// line start pulse leads the first column by this many pixels
	localparam spt_cnt_t SPT_LSP_LEAD = 12'h001;

	// tv encoder clock derived from the core clock
	localparam int SPT_CORE_CLK_KHZ   = 100000;
	localparam int SPT_TV_CLK_KHZ     = 27000;
	localparam int SPT_TV_PERIOD_CYC  = (SPT_CORE_CLK_KHZ + SPT_TV_CLK_KHZ / 2) / SPT_TV_CLK_KHZ;
	localparam spt_cfg_t SPT_TV_PER   = CFW'(SPT_TV_PERIOD_CYC);
	localparam spt_cfg_t SPT_TV_FALL  = CFW'(2 * SPT_TV_PERIOD_CYC);
	localparam spt_cfg_t SPT_TV_RISE  = CFW'(SPT_TV_PERIOD_CYC);
	localparam spt_cfg_t SPT_TV_DIV   = 8'h00;

	typedef enum logic [1:0] {
		SPT_IDLE = 2'b00,
		SPT_ARM  = 2'b01,
		SPT_RUN  = 2'b10
	} spt_state_e;

endpackage

// File: core/spt_clkgen.sv
// interface clock and pixel tick generator
`timescale 1ns/10ps
module spt_clkgen
	import spt_pkg::*;
(
	input  wire logic     core_clk,
	input  wire logic     reset,
	input  wire logic     enable,
	input  wire spt_cfg_t period_cyc,
	input  wire spt_cfg_t fall_half,
	input  wire spt_cfg_t rise_half,
	input  wire spt_cfg_t divider,
	output logic          if_clk,
	output logic          pix_tick
);

	spt_cfg_t        cnt_r;
	spt_cfg_t        cnt_nxt;
	spt_cfg_t        div_r;
	spt_cfg_t        div_nxt;
	logic            clk_r;
	logic            clk_nxt;
	logic            tick_r;
	logic            tick_nxt;
	spt_cfg_t        fall_c;
	spt_cfg_t        rise_c;
	logic [CFW:0]    gap_r;
	logic [2*CFW:0]  gap_want;

	// half periods rounded up to whole core cycles
	function automatic spt_cfg_t half_to_cyc(input spt_cfg_t h);
		logic [CFW:0] t;
		t = {1'b0, h} + {{CFW{1'b0}}, 1'b1};
		half_to_cyc = t[CFW:1];
	endfunction

	always_comb
	begin
		fall_c   = half_to_cyc(fall_half);
		rise_c   = half_to_cyc(rise_half);
		cnt_nxt  = cnt_r;
		div_nxt  = div_r;
		tick_nxt = 1'b0;
		if (!enable)
		begin
			cnt_nxt = '0;
			div_nxt = '0;
		end
		else if (({1'b0, cnt_r} + {{CFW{1'b0}}, 1'b1}) >= {1'b0, period_cyc})
		begin
			cnt_nxt  = '0;
			tick_nxt = (div_r == divider);
			div_nxt  = tick_nxt ? '0 : div_r + 8'h01;
		end
		else
			cnt_nxt = cnt_r + 8'h01;
		clk_nxt = !(enable && cnt_nxt >= rise_c && cnt_nxt < fall_c);
	end

	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			cnt_r  <= '0;
			div_r  <= '0;
			clk_r  <= 1'b1;
			tick_r <= 1'b0;
		end
		else
		begin
			cnt_r  <= cnt_nxt;
			div_r  <= div_nxt;
			clk_r  <= clk_nxt;
			tick_r <= tick_nxt;
		end
	end

	assign if_clk   = clk_r;
	assign pix_tick = tick_r;

	// cycles since the previous tick, checked against period times divider plus one
	always_ff @(posedge core_clk)
	begin
		if (reset || !enable || tick_r)
			gap_r <= {{CFW{1'b0}}, !reset && enable};
		else
			gap_r <= gap_r + {{CFW{1'b0}}, 1'b1};
	end
	assign gap_want = {1'b0, period_cyc} * ({1'b0, divider} + {{CFW{1'b0}}, 1'b1});

	pix_period_a: assert property (@(posedge core_clk) disable iff (reset)
		enable && tick_r && period_cyc != 8'h00 && $stable(divider) && $stable(period_cyc)
		&& gap_r != '0 |-> {{CFW{1'b0}}, gap_r} == gap_want)
		else $error("pixel tick spacing wrong");

	if_clk_low_a: assert property (@(posedge core_clk) disable iff (reset)
		enable && cnt_r >= rise_c && cnt_r < fall_c && $stable(rise_c) && $stable(fall_c) |-> !clk_r)
		else $error("interface clock high inside low window");

endmodule

// File: core/spt_timing_gen.sv
// raster panel timing generator with register port
`timescale 1ns/10ps
module spt_timing_gen
	import spt_pkg::*;
(
	input  wire logic           core_clk,
	input  wire logic           reset,
	input  wire logic [AW-1:0]  reg_addr,
	input  wire logic [DW-1:0]  reg_wdata,
	input  wire logic           reg_wr,
	input  wire logic           reg_rd,
	output logic      [DW-1:0]  reg_rdata,
	input  wire logic [PDW-1:0] pixel_data_in,
	output logic                pixel_req,
	output logic                panel_pixel_clock_out,
	output logic                line_sync_out,
	output logic                frame_sync_out,
	output logic                data_valid_out,
	output logic      [PDW-1:0] panel_data_out,
	output logic                line_start_pulse,
	output logic                gate_clock_pulse,
	output logic                power_save_pulse,
	output logic                polarity_rev_out
);

	logic [DW-1:0] ctrl_r, clk_cfg_r, htot_r, hsyn_r, hsta_r, vtot_r, vsyn_r, pnla_r, pnlb_r, pnlc_r;
	logic [DW-1:0] ctrl_nxt, clk_cfg_nxt, htot_nxt, hsyn_nxt, hsta_nxt, vtot_nxt, vsyn_nxt;
	logic [DW-1:0] pnla_nxt, pnlb_nxt, pnlc_nxt, rdata_r, rdata_nxt;
	spt_state_e    state_r, state_nxt;
	spt_cnt_t      h_cnt_r, h_cnt_nxt, v_cnt_r, v_cnt_nxt, vs_cnt_r, vs_cnt_nxt;
	logic          hs_act_r, hs_act_nxt, vs_act_r, vs_act_nxt, dv_act_r, dv_act_nxt;
	logic          vs_done_r, vs_done_nxt, field_r, field_nxt;
	logic          lsp_r, lsp_nxt, gate_r, gate_nxt, ps_r, ps_nxt, rev_r, rev_nxt;
	logic          clk_out_r, clk_out_nxt, hs_out_r, hs_out_nxt, vs_out_r, vs_out_nxt;
	logic          dv_out_r, dv_out_nxt, req_r, req_nxt;
	logic [PDW-1:0] data_r, data_nxt;
	logic          if_clk, pix_tick, active, tv, pctl, vs_step, vs_start;
	spt_cfg_t      cg_per, cg_fall, cg_rise, cg_div;
	spt_cnt_t      screen_w, active_w, hs_width, hs_delay, first_col;
	spt_cnt_t      screen_h, active_h, vs_width, first_row;
	spt_cnt_t      gate_rise, gate_fall, ps_fall, ps_rise, rev_delay;

	// true for start <= c <= start + len
	function automatic logic in_win(input spt_cnt_t c, input spt_cnt_t start, input spt_cnt_t len);
		logic [CW:0] last;
		last   = {1'b0, start} + {1'b0, len};
		in_win = (c >= start) && ({1'b0, c} <= last);
	endfunction

	assign tv        = ctrl_r[SPT_TV_BIT];
	assign pctl      = ctrl_r[SPT_PCTL_BIT];
	assign screen_w  = htot_r[SPT_LO_LSB +: CW];
	assign active_w  = htot_r[SPT_HI_LSB +: CW];
	assign hs_width  = hsyn_r[SPT_LO_LSB +: CW];
	assign hs_delay  = hsyn_r[SPT_HI_LSB +: CW];
	assign first_col = hsta_r[SPT_LO_LSB +: CW];
	assign screen_h  = vtot_r[SPT_LO_LSB +: CW];
	assign active_h  = vtot_r[SPT_HI_LSB +: CW];
	assign vs_width  = vsyn_r[SPT_LO_LSB +: CW];
	assign first_row = vsyn_r[SPT_HI_LSB +: CW];
	assign gate_rise = pnla_r[SPT_LO_LSB +: CW];
	assign gate_fall = pnla_r[SPT_HI_LSB +: CW];
	assign ps_fall   = pnlb_r[SPT_LO_LSB +: CW];
	assign ps_rise   = pnlb_r[SPT_HI_LSB +: CW];
	assign rev_delay = pnlc_r[SPT_LO_LSB +: CW];
	assign active    = (state_r != SPT_IDLE);

	// tv mode overrides the programmed clock with the fixed encoder rate
	assign cg_per  = tv ? SPT_TV_PER  : clk_cfg_r[SPT_PER_LSB +: CFW];
	assign cg_fall = tv ? SPT_TV_FALL : clk_cfg_r[SPT_FALL_LSB +: CFW];
	assign cg_rise = tv ? SPT_TV_RISE : clk_cfg_r[SPT_RISE_LSB +: CFW];
	assign cg_div  = tv ? SPT_TV_DIV  : clk_cfg_r[SPT_DIV_LSB +: CFW];

	spt_clkgen u_clkgen (
		.core_clk   (core_clk),
		.reset      (reset),
		.enable     (active),
		.period_cyc (cg_per),
		.fall_half  (cg_fall),
		.rise_half  (cg_rise),
		.divider    (cg_div),
		.if_clk     (if_clk),
		.pix_tick   (pix_tick)
	);

	// register port
	always_comb
	begin
		ctrl_nxt    = ctrl_r;
		clk_cfg_nxt = clk_cfg_r;
		htot_nxt    = htot_r;
		hsyn_nxt    = hsyn_r;
		hsta_nxt    = hsta_r;
		vtot_nxt    = vtot_r;
		vsyn_nxt    = vsyn_r;
		pnla_nxt    = pnla_r;
		pnlb_nxt    = pnlb_r;
		pnlc_nxt    = pnlc_r;
		rdata_nxt   = '0;
		if (reg_wr)
		begin
			if (reg_addr == SPT_CTRL_OFS)
				ctrl_nxt = reg_wdata & SPT_CTRL_MASK;
			else if (reg_addr == SPT_CLK_OFS)
				clk_cfg_nxt = reg_wdata;
			else if (reg_addr == SPT_HTOT_OFS)
				htot_nxt = reg_wdata & SPT_PAIR_MASK;
			else if (reg_addr == SPT_HSYN_OFS)
				hsyn_nxt = reg_wdata & SPT_PAIR_MASK;
			else if (reg_addr == SPT_HSTA_OFS)
				hsta_nxt = reg_wdata & SPT_LO_MASK;
			else if (reg_addr == SPT_VTOT_OFS)
				vtot_nxt = reg_wdata & SPT_PAIR_MASK;
			else if (reg_addr == SPT_VSYN_OFS)
				vsyn_nxt = reg_wdata & SPT_PAIR_MASK;
			else if (reg_addr == SPT_PNLA_OFS)
				pnla_nxt = reg_wdata & SPT_PAIR_MASK;
			else if (reg_addr == SPT_PNLB_OFS)
				pnlb_nxt = reg_wdata & SPT_PAIR_MASK;
			else if (reg_addr == SPT_PNLC_OFS)
				pnlc_nxt = reg_wdata & SPT_LO_MASK;
		end
		if (reg_rd)
		begin
			if (reg_addr == SPT_CTRL_OFS)
				rdata_nxt = ctrl_r;
			else if (reg_addr == SPT_CLK_OFS)
				rdata_nxt = clk_cfg_r;
			else if (reg_addr == SPT_HTOT_OFS)
				rdata_nxt = htot_r;
			else if (reg_addr == SPT_HSYN_OFS)
				rdata_nxt = hsyn_r;
			else if (reg_addr == SPT_HSTA_OFS)
				rdata_nxt = hsta_r;
			else if (reg_addr == SPT_VTOT_OFS)
				rdata_nxt = vtot_r;
			else if (reg_addr == SPT_VSYN_OFS)
				rdata_nxt = vsyn_r;
			else if (reg_addr == SPT_PNLA_OFS)
				rdata_nxt = pnla_r;
			else if (reg_addr == SPT_PNLB_OFS)
				rdata_nxt = pnlb_r;
			else if (reg_addr == SPT_PNLC_OFS)
				rdata_nxt = pnlc_r;
			else if (reg_addr == SPT_STAT_OFS)
			begin
				rdata_nxt[SPT_LO_LSB +: CW] = h_cnt_r;
				rdata_nxt[SPT_HI_LSB +: CW] = v_cnt_r;
				rdata_nxt[SPT_RUN_BIT]      = (state_r == SPT_RUN);
				rdata_nxt[SPT_FLD_BIT]      = field_r;
			end
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			ctrl_r    <= SPT_CTRL_RST;
			clk_cfg_r <= SPT_CLK_RST;
			htot_r    <= SPT_TIME_RST;
			hsyn_r    <= SPT_TIME_RST;
			hsta_r    <= SPT_TIME_RST;
			vtot_r    <= SPT_TIME_RST;
			vsyn_r    <= SPT_TIME_RST;
			pnla_r    <= SPT_TIME_RST;
			pnlb_r    <= SPT_TIME_RST;
			pnlc_r    <= SPT_TIME_RST;
			rdata_r   <= '0;
		end
		else
		begin
			ctrl_r    <= ctrl_nxt;
			clk_cfg_r <= clk_cfg_nxt;
			htot_r    <= htot_nxt;
			hsyn_r    <= hsyn_nxt;
			hsta_r    <= hsta_nxt;
			vtot_r    <= vtot_nxt;
			vsyn_r    <= vsyn_nxt;
			pnla_r    <= pnla_nxt;
			pnlb_r    <= pnlb_nxt;
			pnlc_r    <= pnlc_nxt;
			rdata_r   <= rdata_nxt;
		end
	end

	// raster counters and strobes, advanced on each pixel tick
	always_comb
	begin
		state_nxt   = state_r;
		h_cnt_nxt   = h_cnt_r;
		v_cnt_nxt   = v_cnt_r;
		vs_cnt_nxt  = vs_cnt_r;
		vs_done_nxt = vs_done_r;
		field_nxt   = field_r;
		hs_act_nxt  = hs_act_r;
		vs_act_nxt  = vs_act_r;
		dv_act_nxt  = dv_act_r;
		lsp_nxt     = lsp_r;
		gate_nxt    = gate_r;
		ps_nxt      = ps_r;
		rev_nxt     = rev_r;
		data_nxt    = data_r;
		req_nxt     = 1'b0;
		vs_start    = 1'b0;
		vs_step     = 1'b0;
		case (state_r)
			SPT_IDLE:
				if (ctrl_r[SPT_EN_BIT])
					state_nxt = SPT_ARM;
			SPT_ARM:
				if (!ctrl_r[SPT_EN_BIT])
					state_nxt = SPT_IDLE;
				else if (pix_tick)
					state_nxt = SPT_RUN;
			SPT_RUN:
				if (!ctrl_r[SPT_EN_BIT])
					state_nxt = SPT_IDLE;
			default:
				state_nxt = SPT_IDLE;
		endcase
		if (state_nxt == SPT_IDLE)
		begin
			h_cnt_nxt   = '0;
			v_cnt_nxt   = '0;
			vs_cnt_nxt  = '0;
			vs_done_nxt = 1'b0;
			field_nxt   = 1'b0;
			hs_act_nxt  = 1'b0;
			vs_act_nxt  = 1'b0;
			dv_act_nxt  = 1'b0;
			lsp_nxt     = 1'b0;
			gate_nxt    = 1'b0;
			ps_nxt      = 1'b0;
			rev_nxt     = 1'b0;
			data_nxt    = '0;
		end
		else if (pix_tick)
		begin
			if (state_r == SPT_ARM)
			begin
				h_cnt_nxt = '0;
				v_cnt_nxt = '0;
				field_nxt = 1'b0;
			end
			else if (h_cnt_r == screen_w)
			begin
				h_cnt_nxt = '0;
				if (v_cnt_r == screen_h)
				begin
					v_cnt_nxt = '0;
					field_nxt = tv && !field_r;
				end
				else
					v_cnt_nxt = v_cnt_r + 12'h001;
			end
			else
				h_cnt_nxt = h_cnt_r + 12'h001;
			if (tv)
				hs_act_nxt = (h_cnt_nxt == '0);
			else
				hs_act_nxt = in_win(h_cnt_nxt, hs_delay, hs_width);
			// odd field starts with the row, even field half a row later
			if (tv)
				vs_start = (v_cnt_nxt == '0) && (h_cnt_nxt == (field_nxt ? (screen_w >> 1) : '0));
			else
				vs_start = (v_cnt_nxt == '0) && (h_cnt_nxt == hs_delay);
			vs_step = (ctrl_r[SPT_VSLINE_BIT] && !tv) ? (h_cnt_nxt == hs_delay) : 1'b1;
			if (vs_start)
			begin
				vs_act_nxt  = 1'b1;
				vs_cnt_nxt  = '0;
				vs_done_nxt = 1'b0;
			end
			else if (vs_act_r)
			begin
				if (vs_step && !vs_done_r)
				begin
					if (vs_cnt_r == vs_width)
						vs_done_nxt = 1'b1;
					else
						vs_cnt_nxt = vs_cnt_r + 12'h001;
				end
				// outside tv mode, pixel-unit widths stretch to cover the whole line sync pulse
				if (vs_done_nxt && (tv || ctrl_r[SPT_VSLINE_BIT] || !hs_act_nxt))
					vs_act_nxt = 1'b0;
			end
			dv_act_nxt = in_win(h_cnt_nxt, first_col, active_w) && in_win(v_cnt_nxt, first_row, active_h)
				&& !(tv && hs_act_nxt);
			req_nxt  = dv_act_nxt;
			data_nxt = '0;
			if (dv_act_nxt)
			begin
				if (tv)
					data_nxt[SPT_TV_LSB +: SPT_TV_W] = pixel_data_in[SPT_TV_W-1:0];
				else
					data_nxt = pixel_data_in;
			end
			if (pctl && !tv)
			begin
				lsp_nxt = ((h_cnt_nxt + SPT_LSP_LEAD) == first_col);
				if (h_cnt_nxt == gate_rise)
					gate_nxt = 1'b1;
				else if (h_cnt_nxt == gate_fall)
					gate_nxt = 1'b0;
				if (h_cnt_nxt == ps_fall)
					ps_nxt = 1'b0;
				else if (h_cnt_nxt == ps_rise)
					ps_nxt = 1'b1;
				if (h_cnt_nxt == rev_delay)
					rev_nxt = !rev_r;
			end
			else
			begin
				lsp_nxt  = 1'b0;
				gate_nxt = 1'b0;
				ps_nxt   = 1'b0;
				rev_nxt  = 1'b0;
			end
		end
		// polarity applied last so a change shows at once
		clk_out_nxt = (active ? if_clk : 1'b1) ^ ctrl_r[SPT_CLKINV_BIT];
		hs_out_nxt  = (ctrl_r[SPT_HSHI_BIT] && !tv) ? hs_act_nxt : !hs_act_nxt;
		vs_out_nxt  = (ctrl_r[SPT_VSHI_BIT] && !tv) ? vs_act_nxt : !vs_act_nxt;
		dv_out_nxt  = (ctrl_r[SPT_DVHI_BIT] && !tv) ? dv_act_nxt : !dv_act_nxt;
	end

	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			state_r   <= SPT_IDLE;
			h_cnt_r   <= '0;
			v_cnt_r   <= '0;
			vs_cnt_r  <= '0;
			vs_done_r <= 1'b0;
			field_r   <= 1'b0;
			hs_act_r  <= 1'b0;
			vs_act_r  <= 1'b0;
			dv_act_r  <= 1'b0;
			lsp_r     <= 1'b0;
			gate_r    <= 1'b0;
			ps_r      <= 1'b0;
			rev_r     <= 1'b0;
			data_r    <= '0;
			req_r     <= 1'b0;
			clk_out_r <= 1'b1;
			hs_out_r  <= 1'b1;
			vs_out_r  <= 1'b1;
			dv_out_r  <= 1'b1;
		end
		else
		begin
			state_r   <= state_nxt;
			h_cnt_r   <= h_cnt_nxt;
			v_cnt_r   <= v_cnt_nxt;
			vs_cnt_r  <= vs_cnt_nxt;
			vs_done_r <= vs_done_nxt;
			field_r   <= field_nxt;
			hs_act_r  <= hs_act_nxt;
			vs_act_r  <= vs_act_nxt;
			dv_act_r  <= dv_act_nxt;
			lsp_r     <= lsp_nxt;
			gate_r    <= gate_nxt;
			ps_r      <= ps_nxt;
			rev_r     <= rev_nxt;
			data_r    <= data_nxt;
			req_r     <= req_nxt;
			clk_out_r <= clk_out_nxt;
			hs_out_r  <= hs_out_nxt;
			vs_out_r  <= vs_out_nxt;
			dv_out_r  <= dv_out_nxt;
		end
	end

	assign reg_rdata             = rdata_r;
	assign pixel_req             = req_r;
	assign panel_pixel_clock_out = clk_out_r;
	assign line_sync_out         = hs_out_r;
	assign frame_sync_out        = vs_out_r;
	assign data_valid_out        = dv_out_r;
	assign panel_data_out        = data_r;
	assign line_start_pulse      = lsp_r;
	assign gate_clock_pulse      = gate_r;
	assign power_save_pulse      = ps_r;
	assign polarity_rev_out      = rev_r;

	// helpers: pixel ticks inside line sync, and a finished line sync inside frame sync
	logic     hs_prev_r, vs_saw_r;
	spt_cnt_t hs_len_r;
	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			hs_prev_r <= 1'b0;
			vs_saw_r  <= 1'b0;
			hs_len_r  <= '0;
		end
		else
		begin
			hs_prev_r <= hs_act_r;
			vs_saw_r  <= vs_act_r && (vs_saw_r || (hs_prev_r && !hs_act_r));
			hs_len_r  <= !hs_act_r ? '0 : (pix_tick ? hs_len_r + 12'h001 : hs_len_r);
		end
	end

	line_wrap_a: assert property (@(posedge core_clk) disable iff (reset)
		state_r == SPT_RUN && pix_tick && h_cnt_r == screen_w && ctrl_r[SPT_EN_BIT] |=> h_cnt_r == '0)
		else $error("line did not wrap at screen width");

	frame_wrap_a: assert property (@(posedge core_clk) disable iff (reset)
		state_r == SPT_RUN && pix_tick && h_cnt_r == screen_w && v_cnt_r == screen_h && ctrl_r[SPT_EN_BIT]
		|=> v_cnt_r == '0)
		else $error("frame did not wrap at screen height");

	hs_start_a: assert property (@(posedge core_clk) disable iff (reset)
		!tv && $rose(hs_act_r) |-> h_cnt_r == hs_delay && !line_sync_out == !(ctrl_r[SPT_HSHI_BIT]))
		else $error("line sync rose away from its delay");

	hs_width_a: assert property (@(posedge core_clk) disable iff (reset)
		!tv && $fell(hs_act_r) && state_r == SPT_RUN && $stable(hsyn_r) |-> hs_len_r == hs_width + 12'h001)
		else $error("line sync width wrong");

	vs_span_a: assert property (@(posedge core_clk) disable iff (reset)
		!tv && $fell(vs_act_r) && state_r == SPT_RUN |-> vs_saw_r || (hs_prev_r && !hs_act_r))
		else $error("frame sync ended without a full line sync");

	dv_area_a: assert property (@(posedge core_clk) disable iff (reset)
		!dv_act_r |-> panel_data_out == '0 && data_valid_out == (!ctrl_r[SPT_DVHI_BIT] || tv))
		else $error("data driven while not valid");

	tv_hs_one_a: assert property (@(posedge core_clk) disable iff (reset)
		tv && hs_act_r && pix_tick && screen_w != '0 |=> !hs_act_r && line_sync_out)
		else $error("tv line sync longer than one clock");

	tv_gap_a: assert property (@(posedge core_clk) disable iff (reset)
		tv && dv_act_r |-> !hs_act_r && line_sync_out)
		else $error("tv data during line sync");

	odd_field_a: assert property (@(posedge core_clk) disable iff (reset)
		tv && $rose(vs_act_r) && !field_r |-> $rose(hs_act_r))
		else $error("odd field edges not together");

	even_field_a: assert property (@(posedge core_clk) disable iff (reset)
		tv && $rose(vs_act_r) && field_r |-> !$rose(hs_act_r))
		else $error("even field edges coincide");

	rev_toggle_a: assert property (@(posedge core_clk) disable iff (reset)
		pctl && !tv && state_r != SPT_IDLE && ctrl_r[SPT_EN_BIT] && $changed(rev_r) |-> h_cnt_r == rev_delay)
		else $error("reversal toggled at wrong column");

endmodule

// File: testbench/spt_panel_model.sv
// panel model: feeds pixels and measures sync and valid timing
`timescale 1ns/10ps
module spt_panel_model
	import spt_pkg::*;
(
	input  wire logic           core_clk,
	input  wire logic           reset,
	input  wire logic           pixel_req,
	input  wire logic           line_sync_out,
	input  wire logic           frame_sync_out,
	input  wire logic           data_valid_out,
	output logic      [PDW-1:0] pixel_data_in,
	output int                  line_cyc,
	output int                  hs_cyc,
	output int                  dv_cyc,
	output int                  lines_per_frame
);
	logic hs_q;
	logic vs_q;
	logic dv_q;
	int   cnt;
	int   hs_run;
	int   dv_run;
	int   lc;
	always @(posedge core_clk)
	begin
		if (reset)
		begin
			pixel_data_in <= 18'h00000;
			{hs_q, vs_q, dv_q} <= 3'b111;
			cnt    <= 0;
			hs_run <= 0;
			dv_run <= 0;
			lc     <= 0;
		end
		else
		begin
			if (pixel_req)
				pixel_data_in <= pixel_data_in + 18'h00001;
			{hs_q, vs_q, dv_q} <= {line_sync_out, frame_sync_out, data_valid_out};
			cnt <= (hs_q && !line_sync_out) ? 1 : cnt + 1;
			if (hs_q && !line_sync_out)
				line_cyc <= cnt;
			hs_run <= line_sync_out ? 0 : hs_run + 1;
			if (!hs_q && line_sync_out)
				hs_cyc <= hs_run;
			dv_run <= data_valid_out ? 0 : dv_run + 1;
			if (!dv_q && data_valid_out)
				dv_cyc <= dv_run;
			if (vs_q && !frame_sync_out)
			begin
				lines_per_frame <= lc;
				lc <= (hs_q && !line_sync_out) ? 1 : 0;
			end
			else if (hs_q && !line_sync_out)
				lc <= lc + 1;
		end
	end
endmodule

// File: testbench/spt_timing_gen_bench.sv
// register-driven bench for the panel timing generator
`timescale 1ns/10ps
module spt_timing_gen_bench
	import spt_pkg::*;
;
	logic           core_clk;
	logic           reset;
	logic [AW-1:0]  reg_addr;
	logic [DW-1:0]  reg_wdata;
	logic           reg_wr;
	logic           reg_rd;
	logic [DW-1:0]  reg_rdata;
	logic [PDW-1:0] pixel_data_in;
	logic           pixel_req;
	logic           pclk;
	logic           hs;
	logic           vs;
	logic           dv;
	int             line_cyc;
	int             hs_cyc;
	int             dv_cyc;
	int             lpf;
	int             n_fail;
	int             num_checks;
	logic [DW-1:0]  rd_v;
	logic [PDW-1:0] pdata;
	logic           lsp;
	logic           gate;
	logic           ps;
	logic           rev;

	spt_timing_gen dut (.core_clk(core_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pixel_data_in(pixel_data_in),
		.pixel_req(pixel_req), .panel_pixel_clock_out(pclk), .line_sync_out(hs), .frame_sync_out(vs),
		.data_valid_out(dv), .panel_data_out(pdata), .line_start_pulse(lsp), .gate_clock_pulse(gate),
		.power_save_pulse(ps), .polarity_rev_out(rev));
	spt_panel_model panel (.core_clk(core_clk), .reset(reset), .pixel_req(pixel_req), .line_sync_out(hs),
		.frame_sync_out(vs), .data_valid_out(dv), .pixel_data_in(pixel_data_in), .line_cyc(line_cyc),
		.hs_cyc(hs_cyc), .dv_cyc(dv_cyc), .lines_per_frame(lpf));

	initial
	begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	task automatic check(input logic [DW-1:0] seen, input logic [DW-1:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
		@(posedge core_clk);
		{reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [AW-1:0] a);
		@(posedge core_clk);
		{reg_addr, reg_rd} <= {a, 1'b1};
		@(posedge core_clk);
		reg_rd <= 1'b0;
		@(negedge core_clk);
		rd_v = reg_rdata;
	endtask

	task automatic complete_run();
		if (n_fail == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	initial
	begin
		#200000;
		n_fail++;
		complete_run();
	end

	initial
	begin
		n_fail = 0;
		num_checks = 0;
		{reset, reg_addr, reg_wdata, reg_wr, reg_rd} = {1'b1, 8'h00, 32'h0000_0000, 2'b00};
		repeat (8) @(posedge core_clk);
		reset <= 1'b0;
		check({hs, vs, dv, pclk}, 4'hf);
		rd(SPT_CTRL_OFS); check(rd_v, SPT_CTRL_RST);
		rd(SPT_CLK_OFS); check(rd_v, SPT_CLK_RST);
		rd(8'h3c); check(rd_v, 32'h0000_0000);
		// 10-pixel lines, 4 active from column 3, 5 lines per frame
		wr(SPT_HTOT_OFS, 32'h0003_0009);
		wr(SPT_HSYN_OFS, 32'h0002_0001);
		wr(SPT_HSTA_OFS, 32'h0000_0003);
		wr(SPT_VTOT_OFS, 32'h0001_0004);
		wr(SPT_VSYN_OFS, 32'h0001_0000);
		wr(SPT_CTRL_OFS, 32'h0000_0001);
		repeat (500) @(posedge core_clk);
		check(line_cyc, 40);
		check(hs_cyc, 8);
		check(dv_cyc, 16);
		check(lpf, 5);
		rd(SPT_STAT_OFS); check(rd_v[SPT_RUN_BIT], 1'b1);
		wr(SPT_CTRL_OFS, 32'h0000_0000);
		wr(SPT_CLK_OFS, 32'h0104_0804);
		wr(SPT_CTRL_OFS, 32'h0000_0001);
		repeat (1000) @(posedge core_clk);
		check(line_cyc, 80);
		check(hs_cyc, 16);
		// panel-control pulses: column read back just after one edge of each pulse
		wr(SPT_CTRL_OFS, 32'h0000_0000);
		wr(SPT_PNLA_OFS, 32'h0005_0001);
		wr(SPT_PNLB_OFS, 32'h0007_0002);
		wr(SPT_PNLC_OFS, 32'h0000_0004);
		wr(SPT_CTRL_OFS, 32'h0000_0003);
		@(posedge lsp);
		rd(SPT_STAT_OFS);
		check(rd_v[SPT_LO_LSB +: CW], 32'h0000_0002);
		@(posedge gate);
		rd(SPT_STAT_OFS);
		check(rd_v[SPT_LO_LSB +: CW], 32'h0000_0001);
		@(negedge ps);
		rd(SPT_STAT_OFS);
		check(rd_v[SPT_LO_LSB +: CW], 32'h0000_0002);
		@(rev);
		rd(SPT_STAT_OFS);
		check(rd_v[SPT_LO_LSB +: CW], 32'h0000_0004);
		wr(SPT_CTRL_OFS, 32'h0000_0000);
		wr(SPT_CTRL_OFS, 32'h0000_0025);
		repeat (600) @(posedge core_clk);
		@(negedge dv);
		@(negedge core_clk);
		check(pdata[SPT_TV_LSB-1:0], 32'h0000_0000);
		check(hs_cyc, SPT_TV_PERIOD_CYC);
		check(line_cyc, 10 * SPT_TV_PERIOD_CYC);
		complete_run();
	end
endmodule
